/* bench/seq_evt_asserts.sv */
/*
 timing checks on channel 0 of the event output block; the reset check covers all channels.
 assumes it is bound into the top module.
*/
`timescale 1ns/10ps
`default_nettype none
module seq_evt_asserts #(
	parameter int NUM_CH           = 4,
	parameter bit EXPRESS_PLATFORM = 1'b0
) (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              cfg_wr,
	input wire logic [NUM_CH-1:0] cfg_ch_sel,
	input wire logic              cfg_event_line_style,
	input wire logic              cfg_flip_start_level,
	input wire logic              cfg_pol_low,
	input wire logic [NUM_CH-1:0] commit,
	input wire logic [NUM_CH-1:0] initiate,
	input wire logic [NUM_CH-1:0] abort,
	input wire logic [NUM_CH-1:0] iter_done,
	input wire logic [NUM_CH-1:0] event_line,
	input wire logic [NUM_CH-1:0] seq_running,
	input wire logic [NUM_CH-1:0] seq_done
);
	logic style_q;
	logic start_q;
	logic pol_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			style_q <= 1'b0;
			start_q <= 1'b0;
			pol_q   <= 1'b0;
		end else if (cfg_wr && cfg_ch_sel[0]) begin
			style_q <= cfg_event_line_style;
			start_q <= cfg_flip_start_level;
			pol_q   <= cfg_pol_low;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_fire(bit sty);
		sty == style_q && iter_done[0] && seq_running[0] && !commit[0] && !abort[0];
	endsequence
	sequence s_start;
		initiate[0] && !seq_running[0];
	endsequence
	chk_reset_clears: assert property (disable iff (1'b0) !rst_n |=> event_line == '0 && seq_done == '0)
		else $error("outputs not cleared by reset");
	chk_pulse_active: assert property (s_fire(1'b0) |=> (event_line[0] != pol_q) [*8])
		else $error("pulse not active after event");
	chk_toggle_flip: assert property (s_fire(1'b1) |=> event_line[0] != $past(event_line[0]))
		else $error("toggle line did not flip");
	chk_toggle_commit: assert property (style_q && commit[0] |=> event_line[0] == start_q)
		else $error("commit did not load start level");
	chk_run_start: assert property (s_start |=> seq_running[0])
		else $error("initiate did not start run");
	chk_state_excl: assert property (!(seq_running[0] && seq_done[0]))
		else $error("running and done together");
	chk_done_cause: assert property ($rose(seq_done[0]) |-> $past(iter_done[0] && seq_running[0]))
		else $error("done without last iteration");
	chk_done_hold: assert property (seq_done[0] && !initiate[0] |=> seq_done[0])
		else $error("done dropped without initiate");
	chk_run_end: assert property ($past(rst_n) && $fell(seq_running[0]) |-> $past(abort[0] || iter_done[0]))
		else $error("run ended without cause");
endmodule // seq_evt_asserts
bind seq_iteration_event_output seq_evt_asserts #(.NUM_CH(NUM_CH), .EXPRESS_PLATFORM(EXPRESS_PLATFORM)) u_chk (
	.clk, .rst_n, .cfg_wr, .cfg_ch_sel, .cfg_event_line_style, .cfg_flip_start_level, .cfg_pol_low,
	.commit, .initiate, .abort, .iter_done, .event_line, .seq_running, .seq_done);
`default_nettype wire

/* bench/seq_iteration_event_output_bench.sv */
/*
 self-checking bench of the event output block, channel 0 traffic and width writes on channels 1 to 3.
 assumes the trigger bus receiver and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module seq_iteration_event_output_bench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cfg_wr = 1'b0;
	logic [3:0]  cfg_ch_sel = 4'h0;
	logic        cfg_sty = 1'b0;
	logic        cfg_start = 1'b0;
	logic        cfg_pol = 1'b0;
	logic [10:0] cfg_ns = 11'h096;
	logic [26:0] cfg_loop = 27'h1;
	logic        cfg_bnd = 1'b1;
	logic [3:0]  commit = 4'h0;
	logic [3:0]  initiate = 4'h0;
	logic [3:0]  abort = 4'h0;
	logic [3:0]  iter_done = 4'h0;
	logic [2:0]  rd_ch = 3'h0;
	logic [3:0]  event_line;
	logic [3:0]  seq_running;
	logic [3:0]  seq_done;
	logic [26:0] rd_iter_count;
	logic [7:0]  rd_width_cyc;
	int          rx_run;
	int          num_errors = 0;
	int          num_checks = 0;
	seq_iteration_event_output #(.NUM_CH(4), .EXPRESS_PLATFORM(1'b0)) u_dut (
		.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_ch_sel(cfg_ch_sel),
		.cfg_event_line_style(cfg_sty), .cfg_flip_start_level(cfg_start), .cfg_pol_low(cfg_pol),
		.cfg_width_ns(cfg_ns), .cfg_loop_count(cfg_loop), .cfg_bounded_repeat_flag(cfg_bnd),
		.commit(commit), .initiate(initiate), .abort(abort), .iter_done(iter_done),
		.event_line(event_line), .seq_running(seq_running), .seq_done(seq_done),
		.rd_ch(rd_ch), .rd_iter_count(rd_iter_count), .rd_width_cyc(rd_width_cyc));
	trig_bus_rx u_rx (.clk(clk), .line(event_line[0]), .last_run(rx_run));
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic cfg(input logic [3:0] s, input logic t, st, p, input logic [10:0] n, input logic [26:0] l, input logic b);
		@(posedge clk);
		{cfg_wr, cfg_ch_sel, cfg_sty, cfg_start, cfg_pol, cfg_ns, cfg_loop, cfg_bnd} <= {1'b1, s, t, st, p, n, l, b};
		@(posedge clk);
		cfg_wr <= 1'b0;
	endtask
	task automatic strobe(input int w);
		@(posedge clk);
		case (w)
			0: commit[0] <= 1'b1;
			1: initiate[0] <= 1'b1;
			2: iter_done[0] <= 1'b1;
			default: abort[0] <= 1'b1;
		endcase
		@(posedge clk);
		{commit[0], initiate[0], iter_done[0], abort[0]} <= 4'h0;
	endtask
	task automatic t_defaults();
		repeat (3) @(negedge clk);
		`CHK(rd_width_cyc, 8'h13)
		`CHK(event_line, 4'h0)
		strobe(1);
		strobe(2);
		repeat (30) @(negedge clk);
		`CHK(seq_done[0], 1'b1)
		`CHK(rx_run, 32'h13)
		$display("test defaults done");
	endtask
	task automatic t_width();
		logic [10:0] ns [5];
		logic [7:0]  cy [5];
		ns = '{11'h064, 11'h096, 11'h097, 11'h640, 11'h7d0};
		cy = '{8'h13, 8'h13, 8'h13, 8'hc8, 8'hc8};
		@(posedge clk);
		rd_ch <= 3'h1;
		for (int i = 0; i < 5; i++) begin
			cfg(4'h2, 1'b0, 1'b0, 1'b0, ns[i], 27'h1, 1'b1);
			repeat (3) @(negedge clk);
			`CHK(rd_width_cyc, cy[i])
		end
		@(posedge clk);
		rd_ch <= 3'h2;
		repeat (3) @(negedge clk);
		`CHK(rd_width_cyc, 8'h13)
		cfg(4'hc, 1'b0, 1'b0, 1'b0, 11'h640, 27'h1, 1'b1);
		repeat (3) @(negedge clk);
		`CHK(rd_width_cyc, 8'hc8)
		@(posedge clk);
		rd_ch <= 3'h3;
		repeat (3) @(negedge clk);
		`CHK(rd_width_cyc, 8'hc8)
		$display("test width done");
	endtask
	task automatic t_pulse_low();
		cfg(4'h1, 1'b0, 1'b0, 1'b1, 11'h0fa, 27'h1, 1'b1);
		strobe(0);
		repeat (2) @(negedge clk);
		`CHK(event_line[0], 1'b1)
		strobe(1);
		strobe(2);
		repeat (45) @(negedge clk);
		`CHK(rx_run, 32'h20)
		`CHK(event_line[0], 1'b1)
		$display("test pulse low done");
	endtask
	task automatic t_toggle(input logic st);
		cfg(4'h1, 1'b1, st, 1'b0, 11'h096, 27'h4, 1'b1);
		strobe(0);
		repeat (2) @(negedge clk);
		`CHK(event_line[0], st)
		strobe(1);
		for (int k = 1; k < 5; k++) begin
			strobe(2);
			repeat (3) @(negedge clk);
			`CHK(event_line[0], st ^ k[0])
		end
		`CHK(seq_done[0], 1'b1)
		$display("test toggle done");
	endtask
	task automatic t_endless();
		cfg(4'h1, 1'b0, 1'b0, 1'b0, 11'h096, 27'h1, 1'b0);
		rd_ch <= 3'h0;
		strobe(1);
		repeat (3) strobe(2);
		repeat (3) @(negedge clk);
		`CHK(seq_running[0], 1'b1)
		`CHK(rd_iter_count, 27'h3)
		strobe(3);
		repeat (2) @(negedge clk);
		`CHK(seq_running[0], 1'b0)
		$display("test endless done");
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_defaults();
		t_width();
		t_pulse_low();
		t_toggle(1'b1);
		t_toggle(1'b0);
		t_endless();
		end_sim();
	end
endmodule // seq_iteration_event_output_bench
`default_nettype wire

/* bench/trig_bus_rx.sv */
/*
 trigger bus receiver: measures how long the line held its last level.
 assumes the line is sampled on the block clock.
*/
`timescale 1ns/10ps
`default_nettype none
module trig_bus_rx (
	input  wire logic clk,
	input  wire logic line,
	output int        last_run
);
	logic prev = 1'b0;
	int   run  = 0;
	initial last_run = 0;
	always @(posedge clk) begin
		prev <= line;
		if (line != prev) begin
			last_run <= run;
			run <= 1;
		end else begin
			run <= run + 1;
		end
	end
endmodule // trig_bus_rx
`default_nettype wire

/* core/event_line_unit.sv */
/*
 one exported event line: pulse of programmed width and level, or toggling level.
 assumes fire and commit are one-cycle pulses and settings are stable while in use.
*/
`timescale 1ns/10ps
`default_nettype none
module event_line_unit (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// link to control
	seq_evt_if.unit   lnk
);
	logic [seq_evt_pkg::WIDTH_CYC_W-1:0] pulse_cnt_q;
	logic [seq_evt_pkg::WIDTH_CYC_W-1:0] pulse_cnt_d;
	logic                                tog_q;
	logic                                tog_d;
	logic                                line_q;
	logic                                line_d;
	wire logic                           is_toggle;
	wire logic                           pulse_on;

	assign is_toggle   = (lnk.event_line_style == seq_evt_pkg::STYLE_TOGGLE);
	// a new event restarts the pulse for the full width
	assign pulse_cnt_d = (lnk.fire && !is_toggle) ? lnk.width_cyc :                                 // RULE13
		(pulse_cnt_q != '0) ? pulse_cnt_q - 1'b1 : pulse_cnt_q;
	assign pulse_on    = (pulse_cnt_d != '0);
	// start level only counts in toggle style
	assign tog_d       = (lnk.commit && is_toggle) ? (lnk.flip_start_level == seq_evt_pkg::start_level_high) : // RULE4 RULE5 RULE6 RULE7
		(lnk.fire && is_toggle) ? ~tog_q : tog_q;                                                    // RULE5 RULE6 RULE7
	assign line_d      = is_toggle ? tog_d : (pulse_on ^ lnk.pol_low);                              // RULE1 RULE13
	assign lnk.line    = line_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pulse_cnt_q <= '0;
			tog_q       <= 1'b0; // RULE8
			line_q      <= seq_evt_pkg::POL_LOW_DEFAULT;
		end else begin
			pulse_cnt_q <= pulse_cnt_d;
			tog_q       <= tog_d;
			line_q      <= line_d;
		end
	end
endmodule // event_line_unit
`default_nettype wire

/* core/seq_evt_if.sv */
/*
 per-channel link between the control top and one event line unit.
 assumes both ends share the top's clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface seq_evt_if;
	seq_evt_pkg::event_line_style_t          event_line_style;
	seq_evt_pkg::flip_start_level_t          flip_start_level;
	logic                                    pol_low;
	logic [seq_evt_pkg::WIDTH_CYC_W-1:0]     width_cyc;
	logic                                    commit;
	logic                                    fire;
	logic                                    line;

	modport ctl (
		output event_line_style,
		output flip_start_level,
		output pol_low,
		output width_cyc,
		output commit,
		output fire,
		input  line
	);
	modport unit (
		input  event_line_style,
		input  flip_start_level,
		input  pol_low,
		input  width_cyc,
		input  commit,
		input  fire,
		output line
	);
endinterface
`default_nettype wire

/* core/seq_evt_pkg.sv */
/*
 constants and types of the iteration-complete event output and repeat control.
 assumes a single 125 MHz clock; nothing here holds state.
*/
// Function
// RULE1: the event pulse has a selectable active level, active high after reset.
// RULE2: the pulse width is programmable from the platform minimum (150 ns or 250 ns) up to 1.6 us.
// RULE3: after reset the pulse width is the platform minimum, 150 ns or 250 ns.
// RULE4: the start level setting is used only when the line style is toggle.
// RULE5: in toggle style the line takes the start level at commit and flips when an event comes.
// RULE6: with a low start level the line is low at commit, then high, low, high on each later event.
// RULE7: with a high start level the line is high at commit, then low, high, low on each later event.
// RULE8: the start level defaults to low.
// RULE9: after initiation the sequence runs the programmed count of times, 1 to 134217727, default 1.
// RULE10: with the bounded repeat flag cleared the count is ignored and the sequence repeats without end.
// RULE11: the bounded repeat flag selects finite or endless repeat and is set after reset.
// RULE12: every setting is kept separately for each channel, written one by one or all at once.
// RULE13: pulse style gives one pulse per event, toggle style flips the level per event, pulse is default.
// RULE14: the width is turned into whole clock cycles rounded up, so a pulse is never short.
// RULE15: completed iterations are counted and in finite mode the run stops and done rises at the total.
package seq_evt_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam logic [10:0] WIDTH_MIN_PXI_NS  = 11'd150;
	localparam logic [10:0] WIDTH_MIN_PXIE_NS = 11'd250;
	localparam logic [10:0] WIDTH_MAX_NS      = 11'd1600;
	localparam int WIDTH_CYC_W = 8;
	localparam logic [WIDTH_CYC_W-1:0] WIDTH_MIN_PXI_CYC =
		WIDTH_CYC_W'((int'(WIDTH_MIN_PXI_NS) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [WIDTH_CYC_W-1:0] WIDTH_MIN_PXIE_CYC =
		WIDTH_CYC_W'((int'(WIDTH_MIN_PXIE_NS) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int COUNT_W = 27;
	localparam logic [COUNT_W-1:0] LOOP_MIN     = 27'h0000001;
	localparam logic [COUNT_W-1:0] LOOP_MAX     = 27'h7ffffff;
	localparam logic [COUNT_W-1:0] LOOP_DEFAULT = 27'h0000001;
	localparam logic BOUNDED_DEFAULT = 1'b1;
	localparam logic POL_LOW_DEFAULT = 1'b0;

	typedef enum logic {
		STYLE_PULSE  = 1'b0,
		STYLE_TOGGLE = 1'b1
	} event_line_style_t;

	typedef enum logic {
		start_level_low  = 1'b0,
		start_level_high = 1'b1
	} flip_start_level_t;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_RUN  = 2'b01,
		SEQ_DONE = 2'b10
	} seq_state_t;
endpackage

/* core/seq_iteration_event_output.sv */
/*
 iteration-complete event output and sequence repeat control for NUM_CH channels.
 assumes a sequencer pulses iter_done for one cycle per finished iteration and that
 configuration inputs are synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module seq_iteration_event_output #(
	parameter int NUM_CH           = 4,
	parameter bit EXPRESS_PLATFORM = 1'b0
) (
	// clock and reset
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	// configuration write
	input  wire logic                                cfg_wr,
	input  wire logic [NUM_CH-1:0]                   cfg_ch_sel,
	input  wire logic                                cfg_event_line_style,
	input  wire logic                                cfg_flip_start_level,
	input  wire logic                                cfg_pol_low,
	input  wire logic [10:0]                         cfg_width_ns,
	input  wire logic [seq_evt_pkg::COUNT_W-1:0]     cfg_loop_count,
	input  wire logic                                cfg_bounded_repeat_flag,
	// run control
	input  wire logic [NUM_CH-1:0]                   commit,
	input  wire logic [NUM_CH-1:0]                   initiate,
	input  wire logic [NUM_CH-1:0]                   abort,
	input  wire logic [NUM_CH-1:0]                   iter_done,
	// event lines
	output logic      [NUM_CH-1:0]                   event_line,
	// status
	output logic      [NUM_CH-1:0]                   seq_running,
	output logic      [NUM_CH-1:0]                   seq_done,
	input  wire logic [$clog2(NUM_CH+1)-1:0]         rd_ch,
	output logic      [seq_evt_pkg::COUNT_W-1:0]     rd_iter_count,
	output logic      [seq_evt_pkg::WIDTH_CYC_W-1:0] rd_width_cyc
);
	localparam logic [10:0] WIDTH_MIN_NS = EXPRESS_PLATFORM ?
		seq_evt_pkg::WIDTH_MIN_PXIE_NS : seq_evt_pkg::WIDTH_MIN_PXI_NS;
	localparam logic [seq_evt_pkg::WIDTH_CYC_W-1:0] WIDTH_RST_CYC = EXPRESS_PLATFORM ?
		seq_evt_pkg::WIDTH_MIN_PXIE_CYC : seq_evt_pkg::WIDTH_MIN_PXI_CYC;
	localparam logic [11:0] PERIOD_NS   = 12'(seq_evt_pkg::CLK_PERIOD_NS);
	localparam logic [11:0] ROUND_UP_NS = 12'(seq_evt_pkg::CLK_PERIOD_NS - 1);

	// width and loop count taken into range before they are stored
	wire logic [10:0]                         width_clamped_ns;
	wire logic [11:0]                         width_sum_ns;
	wire logic [11:0]                         width_div;
	wire logic [seq_evt_pkg::WIDTH_CYC_W-1:0] width_wr_cyc;
	wire logic [seq_evt_pkg::COUNT_W-1:0]     loop_wr;

	assign width_clamped_ns = (cfg_width_ns < WIDTH_MIN_NS) ? WIDTH_MIN_NS :           // RULE2
		(cfg_width_ns > seq_evt_pkg::WIDTH_MAX_NS) ? seq_evt_pkg::WIDTH_MAX_NS : cfg_width_ns; // RULE2
	assign width_sum_ns     = {1'b0, width_clamped_ns} + ROUND_UP_NS;                  // RULE14
	assign width_div        = width_sum_ns / PERIOD_NS;                                // RULE14
	assign width_wr_cyc     = width_div[seq_evt_pkg::WIDTH_CYC_W-1:0];
	assign loop_wr          = (cfg_loop_count < seq_evt_pkg::LOOP_MIN) ?
		seq_evt_pkg::LOOP_MIN : cfg_loop_count;                                            // RULE9

	// per-channel settings and state
	seq_evt_pkg::event_line_style_t          style_q   [NUM_CH];
	seq_evt_pkg::flip_start_level_t          start_q   [NUM_CH];
	logic                                    pol_low_q [NUM_CH];
	logic [seq_evt_pkg::WIDTH_CYC_W-1:0]     width_q   [NUM_CH];
	logic [seq_evt_pkg::COUNT_W-1:0]         loop_q    [NUM_CH];
	logic                                    bounded_q [NUM_CH];
	logic [seq_evt_pkg::COUNT_W-1:0]         count_q   [NUM_CH];
	seq_evt_pkg::seq_state_t                 state_q   [NUM_CH];
	logic [seq_evt_pkg::COUNT_W-1:0]         rd_count_q;
	logic [seq_evt_pkg::WIDTH_CYC_W-1:0]     rd_width_q;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			wire logic                            wr_here;
			wire logic                            run_here;
			wire logic                            iter_here;
			wire logic [seq_evt_pkg::COUNT_W-1:0] count_inc;
			wire logic                            reach_total;
			seq_evt_pkg::seq_state_t              state_d;
			logic [seq_evt_pkg::COUNT_W-1:0]      count_d;

			// each channel has its own copy; a multi-bit select writes several at once
			assign wr_here     = cfg_wr & cfg_ch_sel[gi];                                           // RULE12
			assign run_here    = (state_q[gi] == seq_evt_pkg::SEQ_RUN);
			assign iter_here   = iter_done[gi] & run_here;
			assign count_inc   = count_q[gi] + 1'b1;
			assign reach_total = bounded_q[gi] && (count_inc >= loop_q[gi]);                        // RULE10 RULE15

			always_comb begin
				state_d = state_q[gi];
				count_d = count_q[gi];
				unique case (state_q[gi])
					seq_evt_pkg::SEQ_IDLE,
					seq_evt_pkg::SEQ_DONE: begin
						if (initiate[gi]) begin
							state_d = seq_evt_pkg::SEQ_RUN; // RULE9
							count_d = '0;
						end
					end
					seq_evt_pkg::SEQ_RUN: begin
						if (abort[gi]) begin
							state_d = seq_evt_pkg::SEQ_IDLE;
						end else if (iter_here) begin
							// endless mode lets the count wrap and never stops
							count_d = count_inc; // RULE15
							if (reach_total) begin
								state_d = seq_evt_pkg::SEQ_DONE; // RULE9 RULE15
							end
						end
					end
					default: begin
						state_d = seq_evt_pkg::SEQ_IDLE;
					end
				endcase
			end

			always_ff @(posedge clk) begin
				if (!rst_n) begin
					style_q[gi]   <= seq_evt_pkg::STYLE_PULSE;          // RULE13
					start_q[gi]   <= seq_evt_pkg::start_level_low;      // RULE8
					pol_low_q[gi] <= seq_evt_pkg::POL_LOW_DEFAULT;      // RULE1
					width_q[gi]   <= WIDTH_RST_CYC;                     // RULE3
					loop_q[gi]    <= seq_evt_pkg::LOOP_DEFAULT;         // RULE9
					bounded_q[gi] <= seq_evt_pkg::BOUNDED_DEFAULT;      // RULE11
				end else if (wr_here) begin
					style_q[gi]   <= seq_evt_pkg::event_line_style_t'(cfg_event_line_style);
					start_q[gi]   <= seq_evt_pkg::flip_start_level_t'(cfg_flip_start_level);
					pol_low_q[gi] <= cfg_pol_low;                       // RULE1
					width_q[gi]   <= width_wr_cyc;                      // RULE2
					loop_q[gi]    <= loop_wr;                           // RULE9
					bounded_q[gi] <= cfg_bounded_repeat_flag;           // RULE11
				end
			end

			always_ff @(posedge clk) begin
				if (!rst_n) begin
					state_q[gi] <= seq_evt_pkg::SEQ_IDLE;
					count_q[gi] <= '0;
				end else begin
					state_q[gi] <= state_d;
					count_q[gi] <= count_d;
				end
			end

			// event line generator for this channel
			seq_evt_if lnk ();

			assign lnk.event_line_style = style_q[gi];
			assign lnk.flip_start_level = start_q[gi];
			assign lnk.pol_low          = pol_low_q[gi];
			assign lnk.width_cyc        = width_q[gi];
			assign lnk.commit           = commit[gi];
			assign lnk.fire             = iter_here;           // RULE13
			assign event_line[gi]       = lnk.line;
			assign seq_running[gi]      = run_here;
			assign seq_done[gi]         = (state_q[gi] == seq_evt_pkg::SEQ_DONE); // RULE15

			event_line_unit u_line (
				.clk   (clk),
				.rst_n (rst_n),
				.lnk   (lnk.unit)
			);
		end
	endgenerate

	// status read-back of one channel, registered
	logic [seq_evt_pkg::COUNT_W-1:0]     rd_count_sel;
	logic [seq_evt_pkg::WIDTH_CYC_W-1:0] rd_width_sel;

	always_comb begin
		rd_count_sel = '0;
		rd_width_sel = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (rd_ch == ($clog2(NUM_CH+1))'(i)) begin
				rd_count_sel = count_q[i];
				rd_width_sel = width_q[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_count_q <= '0;
			rd_width_q <= '0;
		end else begin
			rd_count_q <= rd_count_sel;
			rd_width_q <= rd_width_sel;
		end
	end

	assign rd_iter_count = rd_count_q;
	assign rd_width_cyc  = rd_width_q;
endmodule // seq_iteration_event_output
`default_nettype wire
